//--- design/axis_homing_consts.svh
// Behaviour
// - method 27, clear start: reverse, stop per the stop setting when home sensor activates.
// - method 27, negative limit first: forward, find home falling edge, stop.
// - method 27, home active at start: forward until home falling edge, stop.
// - searching sensors, limits or index uses switch detection speed.
// - reverse edge search, and index methods after the pulse, use zero search speed, decelerating stop.
// - sensor detection stop is decelerating or immediate per acceleration setting.
// - methods 27 and 29: positive limit during homing raises error and aborts.
// - method 29, clear start: reverse, decelerate on home falling edge, stop.
// - method 29, negative limit first: forward until home rising edge, stop.
// - method 29, home active at start: reverse until home falling edge, stop.
// - method 28 unsupported; selecting it starts no run.
// - method 33: reverse, decelerating stop on index pulse.
// - method 34: forward, decelerating stop on index pulse.
// - index methods: on index switch to zero search speed, then stop.
// - methods 33 and 34: either limit during homing raises error and stops.
// - method 35: complete at once at present position, ignoring limits.
// - method 40: reverse at detection speed, complete while current above threshold.
// - method 41: complete once time above current threshold exceeds dwell time.
// - methods 42 and 43 mirror 40 and 41 with opposite start direction.
`ifndef AXIS_HOMING_CONSTS_SVH
`define AXIS_HOMING_CONSTS_SVH
`define HM_METHOD_27     8'h1B
`define HM_METHOD_28     8'h1C
`define HM_METHOD_29     8'h1D
`define HM_METHOD_33     8'h21
`define HM_METHOD_34     8'h22
`define HM_METHOD_35     8'h23
`define HM_METHOD_40     8'h28
`define HM_METHOD_41     8'h29
`define HM_METHOD_42     8'h2A
`define HM_METHOD_43     8'h2B
`define HM_SPEED_RESET   32'h0000_0000
`define HM_DWELL_RESET   32'h0000_0000
`define HM_SYNC_STAGES   2
`endif

//--- design/axis_homing_pkg.sv
package axis_homing_pkg;
    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_SEEK    = 8'h02,
        ST_EXIT    = 8'h04,
        ST_ZERO    = 8'h08,
        ST_STOPPER = 8'h10,
        ST_DECEL   = 8'h20,
        ST_DONE    = 8'h40,
        ST_ERROR   = 8'h80
    } hm_state_t;
    typedef enum logic [1:0] {
        SPD_NONE   = 2'h0,
        SPD_SWITCH = 2'h1,
        SPD_ZERO   = 2'h2
    } hm_speed_sel_t;
endpackage

//--- design/homing_input_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "axis_homing_consts.svh"
module homing_input_sync (
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    // raw sensors: home, neg limit, pos limit, index
    input  wire logic [3:0] raw_in,
    // synchronised level and edges
    output logic      [3:0] level_out,
    output logic      [3:0] rise_out,
    output logic      [3:0] fall_out
);
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_ch
            logic meta_q;
            logic meta_d;
            logic sync_q;
            logic sync_d;
            logic prev_q;
            logic prev_d;
            always_comb begin
                meta_d = raw_in[i];
                sync_d = meta_q;
                prev_d = sync_q;
            end
            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= meta_d;
                    sync_q <= sync_d;
                    prev_q <= prev_d;
                end
            end
            assign level_out[i] = sync_q;
            assign rise_out[i]  = sync_q & ~prev_q;
            assign fall_out[i]  = ~sync_q & prev_q;
        end
    endgenerate
endmodule
`default_nettype wire

//--- design/homing_dwell_timer.sv
`timescale 1ns/100ps
`default_nettype none
module homing_dwell_timer (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    // control
    input  wire logic        run_in,
    input  wire logic        above_in,
    input  wire logic [31:0] dwell_in,
    // result
    output logic             expired_out
);
    logic [31:0] count_q;
    logic [31:0] count_d;
    always_comb begin
        count_d = count_q;
        if (!run_in || !above_in) begin
            count_d = 32'h0000_0000;
        end else if (count_q != 32'hFFFF_FFFF) begin
            count_d = count_q + 32'h0000_0001;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            count_q <= 32'h0000_0000;
        end else begin
            count_q <= count_d;
        end
    end
    // strictly longer than the dwell setting
    assign expired_out = run_in && above_in && (count_q > dwell_in);
endmodule
`default_nettype wire

//--- design/axis_homing_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "axis_homing_consts.svh"
module axis_homing_sequencer
    import axis_homing_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    // host configuration
    input  wire logic        start_in,
    input  wire logic [7:0]  method_in,
    input  wire logic [31:0] switch_speed_in,
    input  wire logic [31:0] zero_speed_in,
    input  wire logic        decel_stop_in,
    input  wire logic [15:0] current_thresh_in,
    input  wire logic [31:0] dwell_cycles_in,
    // field inputs
    input  wire logic        home_sensor_in,
    input  wire logic        neg_limit_sensor_in,
    input  wire logic        pos_limit_sensor_in,
    input  wire logic        index_pulse_in,
    input  wire logic [15:0] motor_current_in,
    // motion command and status
    output logic [31:0]      speed_cmd_out,
    output logic             dir_reverse_out,
    output logic             decel_stop_out,
    output logic             quick_stop_out,
    output logic             busy_out,
    output logic             complete_out,
    output logic             error_out
);
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;
    logic       dwell_expired;

    homing_input_sync u_sync (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .raw_in    ({index_pulse_in, pos_limit_sensor_in, neg_limit_sensor_in, home_sensor_in}),
        .level_out (lvl),
        .rise_out  (rise),
        .fall_out  (fall)
    );

    logic home_l;
    logic nlim_l;
    logic plim_l;
    logic home_r;
    logic home_f;
    logic index_r;
    logic nlim_r;
    assign home_l  = lvl[0];
    assign nlim_l  = lvl[1];
    assign plim_l  = lvl[2];
    assign home_r  = rise[0];
    assign home_f  = fall[0];
    assign nlim_r  = rise[1];
    assign index_r = rise[3];

    hm_state_t     state_q;
    hm_state_t     state_d;
    logic [7:0]    method_q;
    logic [7:0]    method_d;
    hm_speed_sel_t spd_q;
    hm_speed_sel_t spd_d;
    logic          rev_q;
    logic          rev_d;
    logic          dstop_q;
    logic          dstop_d;
    logic          qstop_q;
    logic          qstop_d;
    logic          done_q;
    logic          done_d;
    logic          err_q;
    logic          err_d;
    logic          busy_q;
    logic          busy_d;
    logic          above;
    logic          stopper_run;

    assign above       = motor_current_in > current_thresh_in;
    assign stopper_run = (state_q == ST_STOPPER);

    homing_dwell_timer u_dwell (
        .mclk_in     (mclk_in),
        .reset_in    (reset_in),
        .run_in      (stopper_run),
        .above_in    (above),
        .dwell_in    (dwell_cycles_in),
        .expired_out (dwell_expired)
    );

    logic supported;
    always_comb begin
        case (method_in)
            `HM_METHOD_27, `HM_METHOD_29, `HM_METHOD_33, `HM_METHOD_34, `HM_METHOD_35,
            `HM_METHOD_40, `HM_METHOD_41, `HM_METHOD_42, `HM_METHOD_43: supported = 1'b1;
            default: supported = 1'b0;
        endcase
    end

    logic m27;
    logic m29;
    logic midx;
    logic mstop;
    assign m27   = (method_q == `HM_METHOD_27);
    assign m29   = (method_q == `HM_METHOD_29);
    assign midx  = (method_q == `HM_METHOD_33) || (method_q == `HM_METHOD_34);
    assign mstop = (method_q == `HM_METHOD_40) || (method_q == `HM_METHOD_41) ||
                   (method_q == `HM_METHOD_42) || (method_q == `HM_METHOD_43);

    // shared sensor stop: decelerate or stop at once per setting
    task automatic sensor_stop();
        dstop_d = decel_stop_in;
        qstop_d = ~decel_stop_in;
        spd_d   = SPD_NONE;
    endtask

    always_comb begin
        state_d  = state_q;
        method_d = method_q;
        spd_d    = spd_q;
        rev_d    = rev_q;
        dstop_d  = 1'b0;
        qstop_d  = 1'b0;
        done_d   = done_q;
        err_d    = err_q;
        case (state_q)
            ST_IDLE, ST_DONE, ST_ERROR: begin
                if (state_q != ST_IDLE) begin
                    state_d = ST_IDLE;
                end
                if (start_in && supported) begin
                    method_d = method_in;
                    done_d   = 1'b0;
                    err_d    = 1'b0;
                    spd_d    = SPD_SWITCH;
                    state_d  = ST_SEEK;
                    case (method_in)
                        `HM_METHOD_27: begin
                            rev_d = ~home_l;
                            if (home_l) begin
                                state_d = ST_EXIT;
                            end
                        end
                        `HM_METHOD_29: begin
                            rev_d = 1'b1;
                            if (home_l) begin
                                state_d = ST_ZERO;
                                spd_d   = SPD_ZERO;
                            end
                        end
                        `HM_METHOD_33: rev_d = 1'b1;
                        `HM_METHOD_34: rev_d = 1'b0;
                        `HM_METHOD_35: begin
                            state_d = ST_DONE;
                            spd_d   = SPD_NONE;
                            done_d  = 1'b1;
                        end
                        `HM_METHOD_40, `HM_METHOD_41: begin
                            rev_d   = 1'b1;
                            state_d = ST_STOPPER;
                        end
                        `HM_METHOD_42, `HM_METHOD_43: begin
                            rev_d   = 1'b0;
                            state_d = ST_STOPPER;
                        end
                        default: state_d = ST_IDLE;
                    endcase
                end
            end
            ST_SEEK: begin
                if (m27) begin
                    if (home_r) begin
                        sensor_stop();
                        state_d = ST_DECEL;
                    end else if (nlim_r || nlim_l) begin
                        sensor_stop();
                        rev_d   = 1'b0;
                        spd_d   = SPD_SWITCH;
                        state_d = ST_EXIT;
                    end
                end else if (m29) begin
                    if (home_f) begin
                        sensor_stop();
                        state_d = ST_DECEL;
                    end else if (home_r) begin
                        spd_d   = SPD_ZERO;
                        state_d = ST_ZERO;
                    end else if (nlim_r || nlim_l) begin
                        sensor_stop();
                        rev_d   = 1'b0;
                        spd_d   = SPD_SWITCH;
                        state_d = ST_EXIT;
                    end
                end else if (midx && index_r) begin
                    spd_d   = SPD_ZERO;
                    state_d = ST_ZERO;
                end
            end
            ST_EXIT: begin
                // forward exit: 27 leaves on falling edge, 29 stops on rising edge
                if ((m27 && home_f) || (m29 && home_r)) begin
                    sensor_stop();
                    state_d = ST_DECEL;
                end
            end
            ST_ZERO: begin
                // 29 reverse to falling edge; index methods decelerate right away
                if (midx || home_f) begin
                    dstop_d = 1'b1;
                    spd_d   = SPD_NONE;
                    state_d = ST_DECEL;
                end
            end
            ST_STOPPER: begin
                if ((method_q == `HM_METHOD_40 || method_q == `HM_METHOD_42) && above) begin
                    spd_d   = SPD_NONE;
                    state_d = ST_DECEL;
                end else if (dwell_expired) begin
                    spd_d   = SPD_NONE;
                    state_d = ST_DECEL;
                end
            end
            ST_DECEL: begin
                spd_d   = SPD_NONE;
                done_d  = 1'b1;
                state_d = ST_DONE;
            end
            default: state_d = ST_IDLE;
        endcase
        // limit faults override, only while a motion run is active
        if (state_q == ST_SEEK || state_q == ST_EXIT || state_q == ST_ZERO || state_q == ST_DECEL) begin
            if (((m27 || m29) && plim_l) || (midx && (plim_l || nlim_l))) begin
                state_d = ST_ERROR;
                spd_d   = SPD_NONE;
                dstop_d = 1'b0;
                qstop_d = 1'b1;
                done_d  = 1'b0;
                err_d   = 1'b1;
            end
        end
        // registered so the port comes from a flop, same timing as the state
        busy_d = (state_d != ST_IDLE) && (state_d != ST_DONE) && (state_d != ST_ERROR);
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_q  <= ST_IDLE;
            method_q <= 8'h00;
            spd_q    <= SPD_NONE;
            rev_q    <= 1'b0;
            dstop_q  <= 1'b0;
            qstop_q  <= 1'b0;
            done_q   <= 1'b0;
            err_q    <= 1'b0;
            busy_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            method_q <= method_d;
            spd_q    <= spd_d;
            rev_q    <= rev_d;
            dstop_q  <= dstop_d;
            qstop_q  <= qstop_d;
            done_q   <= done_d;
            err_q    <= err_d;
            busy_q   <= busy_d;
        end
    end

    // speed register: next selection resolved to the host value, so it changes with the selection flop
    logic [31:0] speed_d;
    logic [31:0] speed_q;
    always_comb begin
        case (spd_d)
            SPD_SWITCH: speed_d = switch_speed_in;
            SPD_ZERO:   speed_d = zero_speed_in;
            default:    speed_d = `HM_SPEED_RESET;
        endcase
    end
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            speed_q <= `HM_SPEED_RESET;
        end else begin
            speed_q <= speed_d;
        end
    end

    assign speed_cmd_out   = speed_q;
    assign dir_reverse_out = rev_q;
    assign decel_stop_out  = dstop_q;
    assign quick_stop_out  = qstop_q;
    assign busy_out        = busy_q;
    assign complete_out    = done_q;
    assign error_out       = err_q;
endmodule
`default_nettype wire

//--- dv/axis_homing_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "axis_homing_consts.svh"
module axis_homing_monitor (
    // clock and reset
    input wire logic        mclk_in,
    input wire logic        reset_in,
    // host side
    input wire logic        start_in,
    input wire logic [7:0]  method_in,
    input wire logic [31:0] switch_speed_in,
    input wire logic [31:0] zero_speed_in,
    input wire logic        home_sensor_in,
    // watched outputs
    input wire logic [31:0] speed_cmd_out,
    input wire logic        dir_reverse_out,
    input wire logic        decel_stop_out,
    input wire logic        quick_stop_out,
    input wire logic        busy_out,
    input wire logic        complete_out,
    input wire logic        error_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    logic take;
    logic idx_m;
    assign take = start_in && !busy_out;
    assign idx_m = method_in inside {`HM_METHOD_33, `HM_METHOD_34};
    // only meaningful when the two speeds differ
    sequence s_zero_step;
        busy_out && idx_m && speed_cmd_out == zero_speed_in && $past(speed_cmd_out) == switch_speed_in
            && switch_speed_in != zero_speed_in;
    endsequence
    sequence s_stop_done;
        decel_stop_out && speed_cmd_out == 32'h0 ##1 complete_out && !busy_out;
    endsequence
    a_index_stop: assert property (s_zero_step |=> s_stop_done)
        else $error("index stop order broken");
    // home level is settled before start, so the pin equals its synchronised copy
    a_start_busy: assert property (take && method_in inside {`HM_METHOD_27, `HM_METHOD_29, `HM_METHOD_33,
        `HM_METHOD_34, `HM_METHOD_40, `HM_METHOD_41, `HM_METHOD_42, `HM_METHOD_43}
        |=> busy_out && !complete_out && !error_out
            && speed_cmd_out == $past(((method_in == `HM_METHOD_29) && home_sensor_in) ? zero_speed_in : switch_speed_in))
        else $error("run start wrong");
    a_dir_reverse: assert property (take && method_in inside {`HM_METHOD_33, `HM_METHOD_40} |=> dir_reverse_out)
        else $error("reverse start missing");
    a_dir_forward: assert property (take && method_in inside {`HM_METHOD_34, `HM_METHOD_42} |=> !dir_reverse_out)
        else $error("forward start missing");
    a_no_method28: assert property (take && method_in == `HM_METHOD_28
        |=> !busy_out && $stable(complete_out) && $stable(error_out))
        else $error("unsupported method started");
    a_home_now: assert property (take && method_in == `HM_METHOD_35
        |=> complete_out && !busy_out && !error_out && speed_cmd_out == 32'h0)
        else $error("current position homing wrong");
    a_error_stop: assert property ($rose(error_out) |-> quick_stop_out && speed_cmd_out == 32'h0)
        else $error("error without quick stop");
    a_stop_pulse: assert property (decel_stop_out || quick_stop_out |=> !decel_stop_out && !quick_stop_out)
        else $error("stop pulse too long");
    a_flags_excl: assert property (!(complete_out && error_out))
        else $error("complete and error together");
    a_flag_hold: assert property (complete_out && !start_in |=> complete_out)
        else $error("complete dropped");
    a_idle_still: assert property (!busy_out |-> speed_cmd_out == 32'h0)
        else $error("speed while idle");
endmodule
bind axis_homing_sequencer axis_homing_monitor i_mon (.*);
`default_nettype wire

//--- dv/axis_field_model.sv
`timescale 1ns/100ps
`default_nettype none
module axis_field_model (
    // clock and set-up
    input  wire logic        mclk_in,
    input  wire logic        load_in,
    input  wire logic [15:0] load_pos_in,
    input  wire logic [1:0]  fault_in,
    // motion command
    input  wire logic [31:0] speed_cmd_in,
    input  wire logic        dir_reverse_in,
    // field signals
    output logic             home_out,
    output logic             neg_limit_out,
    output logic             pos_limit_out,
    output logic             index_out,
    output logic [15:0]      current_out,
    output var int           pos_out
);
    localparam int STOP_N = 5;
    localparam int STOP_P = 195;
    logic push;
    // one count per moving cycle; stoppers clamp travel
    always_ff @(posedge mclk_in) begin
        if (load_in)
            pos_out <= int'(load_pos_in);
        else if (speed_cmd_in != 32'h0 && !push)
            pos_out <= dir_reverse_in ? pos_out - 1 : pos_out + 1;
    end
    always_comb begin
        push = dir_reverse_in ? pos_out <= STOP_N : pos_out >= STOP_P;
        home_out = pos_out >= 60 && pos_out <= 90;
        neg_limit_out = pos_out <= 10 || fault_in[0];
        pos_limit_out = pos_out >= 190 || fault_in[1];
        index_out = pos_out % 32 == 0;
        current_out = (push && speed_cmd_in != 32'h0) ? 16'h0400 : 16'h0010;
    end
endmodule
`default_nettype wire

//--- dv/test_axis_homing_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module test_axis_homing_sequencer;
    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        start_in = 1'b0;
    logic [7:0]  method_in = 8'h00;
    logic [31:0] switch_speed_in = 32'h1;
    logic [31:0] zero_speed_in = 32'h2;
    logic        decel_stop_in = 1'b1;
    logic [15:0] current_thresh_in = 16'h0200;
    logic [31:0] dwell_cycles_in = 32'h8;
    logic        home_sensor_in, neg_limit_sensor_in, pos_limit_sensor_in, index_pulse_in;
    logic [15:0] motor_current_in;
    logic [31:0] speed_cmd_out;
    logic        dir_reverse_out, decel_stop_out, quick_stop_out, busy_out, complete_out, error_out;
    logic        load = 1'b0;
    logic [15:0] load_pos = 16'h0;
    logic [1:0]  fault = 2'h0;
    int          pos;
    int          n_fail = 0;
    int          n_checks = 0;
    logic [31:0] rng = 32'hF7480B54;
    // method, start, pos low, pos high, fault, error, reverse, zero phase
    int tbl [16][8] = '{
        '{27, 150, 78, 90, 0, 0, 1, 0}, '{27, 30, 91, 103, 0, 0, 1, 0}, '{27, 75, 91, 103, 0, 0, 0, 0},
        '{29, 150, 47, 59, 0, 0, 1, 1}, '{29, 30, 60, 72, 0, 0, 1, 0}, '{29, 75, 47, 59, 0, 0, 1, 1},
        '{33, 150, 116, 128, 0, 0, 1, 1}, '{34, 150, 160, 172, 0, 0, 0, 1}, '{40, 150, 5, 5, 0, 0, 1, 0},
        '{41, 150, 5, 5, 0, 0, 1, 0}, '{42, 50, 195, 195, 0, 0, 0, 0}, '{43, 50, 195, 195, 0, 0, 0, 0},
        '{33, 155, 0, 255, 1, 1, 1, 0}, '{34, 130, 0, 255, 2, 1, 0, 0}, '{27, 150, 0, 255, 2, 1, 1, 0},
        '{29, 150, 0, 255, 2, 1, 1, 0}};
    axis_homing_sequencer i_dut (.*);
    axis_field_model i_field (.mclk_in(mclk_in), .load_in(load), .load_pos_in(load_pos), .fault_in(fault),
        .speed_cmd_in(speed_cmd_out), .dir_reverse_in(dir_reverse_out), .home_out(home_sensor_in),
        .neg_limit_out(neg_limit_sensor_in), .pos_limit_out(pos_limit_sensor_in), .index_out(index_pulse_in),
        .current_out(motor_current_in), .pos_out(pos));
    always #12.5 mclk_in = ~mclk_in;
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // pulse start for one cycle at the given method, then release it; does not wait for the run to end
    task automatic pulse_start(input logic [7:0] m);
        method_in <= m;
        start_in <= 1'b1;
        @(posedge mclk_in);
        start_in <= 1'b0;
        #1;
    endtask
    task automatic run(input int r);
        int n, nd, nq, nh, zs;
        n = 0;
        nd = 0;
        nq = 0;
        nh = 0;
        zs = 0;
        rng = xs(rng);
        @(posedge mclk_in);
        load <= 1'b1;
        fault <= 2'h0;
        load_pos <= 16'(tbl[r][1]);
        switch_speed_in <= {16'h0, rng[15:0]} | 32'h1;
        zero_speed_in <= {16'h1, rng[15:0]};
        decel_stop_in <= rng[16];
        dwell_cycles_in <= 32'h8 + 32'(rng[21:17]);
        @(posedge mclk_in);
        load <= 1'b0;
        // let the sensor synchroniser settle on the new position
        repeat (6) @(posedge mclk_in);
        pulse_start(8'(tbl[r][0]));
        `CHK("busy", 1'b1, busy_out)
        `CHK("flags clear", 2'h0, {complete_out, error_out})
        // method 29 inside the home sensor goes straight to the zero search
        `CHK("start speed", (tbl[r][0] == 29 && tbl[r][1] >= 60 && tbl[r][1] <= 90) ? zero_speed_in : switch_speed_in, speed_cmd_out)
        `CHK("direction", 1'(tbl[r][6]), dir_reverse_out)
        while (busy_out === 1'b1 && n < 2000) begin
            @(posedge mclk_in);
            if (n == 20)
                fault <= 2'(tbl[r][4]);
            #1;
            n++;
            nd += int'(decel_stop_out);
            nq += int'(quick_stop_out);
            if (busy_out && motor_current_in > current_thresh_in)
                nh++;
            if (speed_cmd_out === zero_speed_in)
                zs = 1;
        end
        `CHK("run ended", 1'b1, n < 2000)
        `CHK("error", 1'(tbl[r][5]), error_out)
        `CHK("complete", 1'(!tbl[r][5]), complete_out)
        `CHK("speed stopped", 32'h0, speed_cmd_out)
        `CHK("end position", 1'b1, pos >= tbl[r][2] && pos <= tbl[r][3])
        if (tbl[r][7] != 0)
            `CHK("zero speed phase", 1, zs)
        // a zero speed search always ends decelerating, whatever the stop setting
        if (tbl[r][7] != 0 && tbl[r][5] == 0)
            `CHK("decelerating stop", 1'b1, nd > 0)
        if (tbl[r][0] inside {27, 29} && tbl[r][5] == 0 && tbl[r][7] == 0)
            `CHK("stop kind", 1'b1, decel_stop_in ? nd > 0 : nq > 0)
        if (tbl[r][0] inside {41, 43})
            `CHK("dwell", 1'b1, nh > int'(dwell_cycles_in) && nh <= int'(dwell_cycles_in) + 6)
    endtask
    initial begin
        repeat (10) @(posedge mclk_in);
        reset_in <= 1'b0;
        for (int r = 0; r < 16; r++)
            run(r);
        @(posedge mclk_in);
        pulse_start(8'h1C);
        `CHK("method 28 idle", 1'b0, busy_out)
        `CHK("method 28 flags", 2'h1, {complete_out, error_out})
        @(posedge mclk_in);
        fault <= 2'h3;
        repeat (4) @(posedge mclk_in);
        pulse_start(8'h23);
        `CHK("home here", 4'h8, {complete_out, error_out, busy_out, dir_reverse_out & 1'b0})
        `CHK("home here speed", 32'h0, speed_cmd_out)
        end_of_test();
    end
    initial begin
        #(25 * 40000);
        n_fail++;
        end_of_test();
    end
endmodule
`default_nettype wire
